/* File: shared/sfce_defs.svh */
// constants for the status flag and condition block
`ifndef SFCE_DEFS_SVH
`define SFCE_DEFS_SVH

`define SFCE_W              32
`define SFCE_CC_O           4'h0
`define SFCE_CC_NO          4'h1
`define SFCE_CC_B           4'h2
`define SFCE_CC_AE          4'h3
`define SFCE_CC_E           4'h4
`define SFCE_CC_NE          4'h5
`define SFCE_CC_BE          4'h6
`define SFCE_CC_A           4'h7
`define SFCE_CC_S           4'h8
`define SFCE_CC_NS          4'h9
`define SFCE_CC_P           4'ha
`define SFCE_CC_NP          4'hb
`define SFCE_CC_L           4'hc
`define SFCE_CC_GE          4'hd
`define SFCE_CC_LE          4'he
`define SFCE_CC_G           4'hf
`define SFCE_FLAGS_RST      11'h000
`define SFCE_IDX_STEP       32'h0000_0001

`endif

/* File: shared/sfce_pkg.sv */
// types for the status flag and condition block
package sfce_pkg;

    typedef struct packed {
        logic overflow_flag;
        logic sign_flag;
        logic zero_flag;
        logic adjust_flag;
        logic parity_flag;
        logic carry_flag;
    } sfce_arith_s;

    typedef struct packed {
        logic trap_flag;
        logic int_enable_flag;
        logic direction_flag;
        logic nested_task_flag;
        logic resume_flag;
    } sfce_ctrl_s;

    typedef enum logic [1:0] {
        SFCE_SZ_BYTE,
        SFCE_SZ_WORD,
        SFCE_SZ_DWORD
    } sfce_size_e;

    typedef enum logic [1:0] {
        SFCE_OP_ADD,
        SFCE_OP_SUB,
        SFCE_OP_LOGIC
    } sfce_op_e;

    typedef logic [3:0] sfce_cc_t;

endpackage

/* File: verilog/sfce_cond_eval.sv */
// combinational condition subcode evaluator
`timescale 1ns/1ns
`include "sfce_defs.svh"
module sfce_cond_eval
    import sfce_pkg::*;
(
    // flags and subcode
    input  wire sfce_pkg::sfce_arith_s flags,
    input  wire sfce_pkg::sfce_cc_t    cc,
    // result
    output logic                       cond_true
);
    logic base;

    always_comb
    begin
        base = 1'b0;
        case (cc[3:1])
            3'h0: base = flags.overflow_flag;
            3'h1: base = flags.carry_flag;
            3'h2: base = flags.zero_flag;
            3'h3: base = flags.carry_flag | flags.zero_flag;
            3'h4: base = flags.sign_flag;
            3'h5: base = flags.parity_flag;
            3'h6: base = flags.sign_flag ^ flags.overflow_flag;
            3'h7: base = (flags.sign_flag ^ flags.overflow_flag) | flags.zero_flag;
            default: base = 1'b0;
        endcase
        cond_true = base ^ cc[0];
    end
endmodule

/* File: verilog/sfce_flag_calc.sv */
// arithmetic flag computation from a result
`timescale 1ns/1ns
`include "sfce_defs.svh"
module sfce_flag_calc
    import sfce_pkg::*;
#(
    parameter int W = `SFCE_W
)
(
    // operands
    input  wire logic [W-1:0]          op_a,
    input  wire logic [W-1:0]          op_b,
    input  wire logic                  carry_in,
    input  wire sfce_pkg::sfce_op_e    op,
    input  wire sfce_pkg::sfce_size_e  size,
    // outputs
    output logic [W-1:0]               result,
    output sfce_pkg::sfce_arith_s      flags
);
    logic [W:0]   sum;
    logic [W-1:0] b_eff;
    logic [4:0]   low_sum;
    int           msb;
    logic         c_msb;
    logic         a_s;
    logic         b_s;
    logic         r_s;

    always_comb
    begin
        msb = W - 1;
        if (size == SFCE_SZ_BYTE)
            msb = 7;
        else if (size == SFCE_SZ_WORD)
            msb = 15;
        b_eff = (op == SFCE_OP_SUB) ? ~op_b : op_b;
        sum = {1'b0, op_a} + {1'b0, b_eff} + {{W{1'b0}}, carry_in ^ (op == SFCE_OP_SUB)};
        low_sum = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]}
                + {4'h0, carry_in ^ (op == SFCE_OP_SUB)};
        result = (op == SFCE_OP_LOGIC) ? op_a : sum[W-1:0];
        // carry into the bit above the size, not that bit of the full sum
        if (msb + 1 < W)
            c_msb = sum[msb+1] ^ op_a[msb+1] ^ b_eff[msb+1];
        else
            c_msb = sum[W];
        a_s = op_a[msb];
        b_s = b_eff[msb];
        r_s = result[msb];
        flags = '0;
        if (op != SFCE_OP_LOGIC)
        begin
            flags.overflow_flag = (a_s == b_s) && (r_s != a_s);
            // carry or borrow out of msb
            flags.carry_flag = c_msb ^ (op == SFCE_OP_SUB);
            flags.adjust_flag = low_sum[4] ^ (op == SFCE_OP_SUB);
        end
        flags.sign_flag = r_s;
        flags.zero_flag = 1'b1;
        for (int i = 0; i < W; i++)
            if (i <= msb && result[i])
                flags.zero_flag = 1'b0;
        flags.parity_flag = ~^result[7:0];
    end
endmodule

/* File: verilog/sfce_core.sv */
// flag register, control flags and condition evaluation
// What this block does
// - overflow set when signed result does not fit the operand size
// - sign flag copies result most significant bit
// - zero flag set when every result bit within the operand size is zero
// - adjust flag on carry or borrow across low four bits
// - parity flag set when low byte has even ones
// - carry flag on carry or borrow at the top bit
// - trap flag set raises debug trap after every instruction retired while resume flag is clear
// - maskable interrupts accepted only while interrupt enable set
// - direction flag set decrements index registers, clear increments
// - nested task flag records task chaining for task return
// - resume flag suppresses debug exceptions while set
// - four bit subcode, odd codes invert; overflow, sign, parity tests
// - unsigned below, equal, below-or-equal tests on carry and zero
// - codes 1100 and 1101 test sign xor overflow
// - codes 1110 and 1111 test sign xor overflow or zero
// - unsigned conditions use only carry and zero
// - signed conditions use sign, overflow and zero
`timescale 1ns/1ns
`include "sfce_defs.svh"
module sfce_core
    import sfce_pkg::*;
#(
    parameter int W = `SFCE_W
)
(
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // alu operation
    input  wire logic                  alu_valid,
    input  wire logic [W-1:0]          alu_a,
    input  wire logic [W-1:0]          alu_b,
    input  wire sfce_pkg::sfce_op_e    alu_op,
    input  wire sfce_pkg::sfce_size_e  alu_size,
    input  wire logic                  alu_use_carry,
    output logic [W-1:0]               alu_result,
    // flag loads
    input  wire logic                  arith_load,
    input  wire sfce_pkg::sfce_arith_s arith_load_val,
    input  wire logic                  ctrl_load,
    input  wire sfce_pkg::sfce_ctrl_s  ctrl_load_val,
    // instruction retire and interrupts
    input  wire logic                  insn_retire,
    input  wire logic                  intr_req,
    output logic                       intr_accept,
    output logic                       debug_trap,
    input  wire logic                  debug_exc_req,
    output logic                       debug_exc_take,
    // task switch
    input  wire logic                  task_nest_enter,
    input  wire logic                  task_return,
    output logic                       task_return_nested,
    // string index stepping
    input  wire logic                  str_step,
    input  wire logic [W-1:0]          src_index_in,
    input  wire logic [W-1:0]          dst_index_in,
    output logic [W-1:0]               source_index_register,
    output logic [W-1:0]               destination_index_register,
    // condition evaluation
    input  wire sfce_pkg::sfce_cc_t    cc,
    output logic                       cond_true,
    // flag state
    output sfce_pkg::sfce_arith_s      arith_flags,
    output sfce_pkg::sfce_ctrl_s       ctrl_flags
);
    sfce_arith_s arith_r;
    sfce_ctrl_s  ctrl_r;
    sfce_arith_s calc_flags;
    logic [W-1:0] calc_result;
    logic         trap_pend_r;
    logic [W-1:0] step;

    assign arith_flags = arith_r;
    assign ctrl_flags  = ctrl_r;
    assign step        = W'(`SFCE_IDX_STEP);

    // ----------------------------------------
    // flag computation
    // ----------------------------------------
    sfce_flag_calc #(.W(W)) u_calc
    (
        .op_a     (alu_a),
        .op_b     (alu_b),
        .carry_in (alu_use_carry & arith_r.carry_flag),
        .op       (alu_op),
        .size     (alu_size),
        .result   (calc_result),
        .flags    (calc_flags)
    );

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            alu_result <= '0;
        else if (alu_valid)
            alu_result <= calc_result;
    end

    // ----------------------------------------
    // arithmetic flag register
    // ----------------------------------------
    // flags latched from alu
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            arith_r <= '0;
        else if (alu_valid)
            arith_r <= calc_flags;
        else if (arith_load)
            arith_r <= arith_load_val;
    end

    // ----------------------------------------
    // control flag register
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_r <= '0;
        else if (ctrl_load)
            ctrl_r <= ctrl_load_val;
        else
        begin
            if (task_nest_enter)
                ctrl_r.nested_task_flag <= 1'b1;
            else if (task_return)
                ctrl_r.nested_task_flag <= 1'b0;
            // resume cleared after an instruction completes
            if (insn_retire)
                ctrl_r.resume_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // single step and debug
    // ----------------------------------------
    // trap after each retired instruction
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            trap_pend_r <= 1'b0;
        else
            trap_pend_r <= insn_retire & ctrl_r.trap_flag & ~ctrl_r.resume_flag;
    end
    assign debug_trap = trap_pend_r;

    assign debug_exc_take = debug_exc_req & ~ctrl_r.resume_flag;

    assign intr_accept = intr_req & ctrl_r.int_enable_flag;

    assign task_return_nested = task_return & ctrl_r.nested_task_flag;

    // ----------------------------------------
    // string index stepping
    // ----------------------------------------
    // direction selects step sign
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            source_index_register      <= '0;
            destination_index_register <= '0;
        end
        else if (str_step)
        begin
            if (ctrl_r.direction_flag)
            begin
                source_index_register      <= src_index_in - step;
                destination_index_register <= dst_index_in - step;
            end
            else
            begin
                source_index_register      <= src_index_in + step;
                destination_index_register <= dst_index_in + step;
            end
        end
    end

    // ----------------------------------------
    // condition evaluation
    // ----------------------------------------
    // same cycle result
    sfce_cond_eval u_cond
    (
        .flags     (arith_r),
        .cc        (cc),
        .cond_true (cond_true)
    );

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_intr_gate;
        @(posedge sys_clk) disable iff (!rst_n)
        intr_accept == (intr_req && ctrl_r.int_enable_flag);
    endproperty
    a_intr_gate: assert property (p_intr_gate) else $error("interrupt gate wrong");

    sequence s_step_retire;
        insn_retire && ctrl_r.trap_flag && !ctrl_r.resume_flag;
    endsequence
    property p_trap;
        @(posedge sys_clk) disable iff (!rst_n)
        s_step_retire |=> debug_trap;
    endproperty
    a_trap: assert property (p_trap) else $error("single step trap missing");

    property p_no_trap;
        @(posedge sys_clk) disable iff (!rst_n)
        !ctrl_r.trap_flag |=> !debug_trap;
    endproperty
    a_no_trap: assert property (p_no_trap) else $error("spurious trap");

    property p_resume;
        @(posedge sys_clk) disable iff (!rst_n)
        ctrl_r.resume_flag |-> !debug_exc_take;
    endproperty
    a_resume: assert property (p_resume) else $error("debug not suppressed");

    property p_dir;
        @(posedge sys_clk) disable iff (!rst_n)
        (str_step && ctrl_r.direction_flag)
            |=> source_index_register == $past(src_index_in) - step;
    endproperty
    a_dir: assert property (p_dir) else $error("index not decremented");

    property p_zero_cc;
        @(posedge sys_clk) disable iff (!rst_n)
        (cc == `SFCE_CC_E) |-> cond_true == arith_r.zero_flag;
    endproperty
    a_zero_cc: assert property (p_zero_cc) else $error("equal test wrong");

    property p_signed_cc;
        @(posedge sys_clk) disable iff (!rst_n)
        (cc == `SFCE_CC_G)
            |-> cond_true == !((arith_r.sign_flag ^ arith_r.overflow_flag) | arith_r.zero_flag);
    endproperty
    a_signed_cc: assert property (p_signed_cc) else $error("greater test wrong");

    property p_zero_flag;
        @(posedge sys_clk) disable iff (!rst_n)
        (alu_valid && alu_size == SFCE_SZ_DWORD)
            |=> arith_r.zero_flag == (alu_result == '0);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

    property p_parity;
        @(posedge sys_clk) disable iff (!rst_n)
        alu_valid |=> arith_r.parity_flag == ~^alu_result[7:0];
    endproperty
    a_parity: assert property (p_parity) else $error("parity flag wrong");

    property p_less_cc;
        @(posedge sys_clk) disable iff (!rst_n)
        (cc == `SFCE_CC_L) |-> cond_true == (arith_r.sign_flag ^ arith_r.overflow_flag);
    endproperty
    a_less_cc: assert property (p_less_cc) else $error("less test wrong");

    property p_dir_dst;
        @(posedge sys_clk) disable iff (!rst_n)
        (str_step && ctrl_r.direction_flag)
            |=> destination_index_register == $past(dst_index_in) - step;
    endproperty
    a_dir_dst: assert property (p_dir_dst) else $error("dest index not decremented");

    property p_inc;
        @(posedge sys_clk) disable iff (!rst_n)
        (str_step && !ctrl_r.direction_flag)
            |=> source_index_register == $past(src_index_in) + step;
    endproperty
    a_inc: assert property (p_inc) else $error("index not incremented");

    property p_nest_set;
        @(posedge sys_clk) disable iff (!rst_n)
        (task_nest_enter && !ctrl_load) |=> ctrl_r.nested_task_flag;
    endproperty
    a_nest_set: assert property (p_nest_set) else $error("nesting not recorded");

    property p_nest_clr;
        @(posedge sys_clk) disable iff (!rst_n)
        (task_return && !task_nest_enter && !ctrl_load) |=> !ctrl_r.nested_task_flag;
    endproperty
    a_nest_clr: assert property (p_nest_clr) else $error("nesting not cleared");

    property p_resume_clr;
        @(posedge sys_clk) disable iff (!rst_n)
        (insn_retire && !ctrl_load) |=> !ctrl_r.resume_flag;
    endproperty
    a_resume_clr: assert property (p_resume_clr) else $error("resume not cleared");

    property p_over_cc;
        @(posedge sys_clk) disable iff (!rst_n)
        (cc == `SFCE_CC_O) |-> cond_true == arith_r.overflow_flag;
    endproperty
    a_over_cc: assert property (p_over_cc) else $error("overflow test wrong");

    property p_sign_cc;
        @(posedge sys_clk) disable iff (!rst_n)
        (cc == `SFCE_CC_S) |-> cond_true == arith_r.sign_flag;
    endproperty
    a_sign_cc: assert property (p_sign_cc) else $error("sign test wrong");

    property p_par_cc;
        @(posedge sys_clk) disable iff (!rst_n)
        (cc == `SFCE_CC_NP) |-> cond_true == !arith_r.parity_flag;
    endproperty
    a_par_cc: assert property (p_par_cc) else $error("no parity test wrong");

    property p_below_cc;
        @(posedge sys_clk) disable iff (!rst_n)
        (cc == `SFCE_CC_B) |-> cond_true == arith_r.carry_flag;
    endproperty
    a_below_cc: assert property (p_below_cc) else $error("below test wrong");

    property p_above_cc;
        @(posedge sys_clk) disable iff (!rst_n)
        (cc == `SFCE_CC_A) |-> cond_true == !(arith_r.carry_flag | arith_r.zero_flag);
    endproperty
    a_above_cc: assert property (p_above_cc) else $error("above test wrong");

    property p_ge_cc;
        @(posedge sys_clk) disable iff (!rst_n)
        (cc == `SFCE_CC_GE) |-> cond_true == !(arith_r.sign_flag ^ arith_r.overflow_flag);
    endproperty
    a_ge_cc: assert property (p_ge_cc) else $error("greater or equal test wrong");

    property p_le_cc;
        @(posedge sys_clk) disable iff (!rst_n)
        (cc == `SFCE_CC_LE)
            |-> cond_true == ((arith_r.sign_flag ^ arith_r.overflow_flag) | arith_r.zero_flag);
    endproperty
    a_le_cc: assert property (p_le_cc) else $error("less or equal test wrong");

    property p_logic_clr;
        @(posedge sys_clk) disable iff (!rst_n)
        (alu_valid && alu_op == SFCE_OP_LOGIC)
            |=> !(arith_r.overflow_flag || arith_r.carry_flag);
    endproperty
    a_logic_clr: assert property (p_logic_clr) else $error("logic op left flags set");

    property p_sign_flag;
        @(posedge sys_clk) disable iff (!rst_n)
        (alu_valid && alu_size == SFCE_SZ_DWORD) |=> arith_r.sign_flag == alu_result[W-1];
    endproperty
    a_sign_flag: assert property (p_sign_flag) else $error("sign flag wrong");
endmodule

/* File: tb/sfce_core_tb_top.sv */
// self-checking testbench for the status flag core
`timescale 1ns/1ns
module sfce_core_tb_top;
    import sfce_pkg::*;

    logic          sys_clk;
    logic          rst_n;
    logic          alu_valid;
    logic [31:0]   alu_a;
    logic [31:0]   alu_b;
    sfce_op_e      alu_op;
    sfce_size_e    alu_size;
    logic          alu_use_carry;
    logic [31:0]   alu_result;
    logic          arith_load;
    sfce_arith_s   arith_load_val;
    logic          ctrl_load;
    sfce_ctrl_s    ctrl_load_val;
    logic          insn_retire;
    logic          intr_req;
    logic          intr_accept;
    logic          debug_trap;
    logic          debug_exc_req;
    logic          debug_exc_take;
    logic          task_nest_enter;
    logic          task_return;
    logic          task_return_nested;
    logic          str_step;
    logic [31:0]   src_index_in;
    logic [31:0]   dst_index_in;
    logic [31:0]   source_index_register;
    logic [31:0]   destination_index_register;
    sfce_cc_t      cc;
    logic          cond_true;
    sfce_arith_s   arith_flags;
    sfce_ctrl_s    ctrl_flags;
    int            n_errors;
    int            check_count;
    integer        seed;
    logic [5:0]    cur;
    logic [37:0]   m;
    logic [31:0]   a;
    logic [31:0]   b;
    logic [31:0]   rv;

    sfce_core #(.W(32)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .alu_valid(alu_valid),
        .alu_a(alu_a), .alu_b(alu_b), .alu_op(alu_op), .alu_size(alu_size),
        .alu_use_carry(alu_use_carry), .alu_result(alu_result), .arith_load(arith_load),
        .arith_load_val(arith_load_val), .ctrl_load(ctrl_load),
        .ctrl_load_val(ctrl_load_val), .insn_retire(insn_retire), .intr_req(intr_req),
        .intr_accept(intr_accept), .debug_trap(debug_trap), .debug_exc_req(debug_exc_req),
        .debug_exc_take(debug_exc_take), .task_nest_enter(task_nest_enter),
        .task_return(task_return), .task_return_nested(task_return_nested),
        .str_step(str_step), .src_index_in(src_index_in), .dst_index_in(dst_index_in),
        .source_index_register(source_index_register),
        .destination_index_register(destination_index_register), .cc(cc),
        .cond_true(cond_true), .arith_flags(arith_flags), .ctrl_flags(ctrl_flags));

    // ------------------------------------------------------------
    // clock, verdict and helpers
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        if (n_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    function automatic logic [31:0] msk(input sfce_size_e sz);
        return (sz == SFCE_SZ_BYTE) ? 32'h0000_00ff :
               (sz == SFCE_SZ_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
    endfunction

    // result and flags {of sf zf af pf cf} expected from an operation
    function automatic logic [37:0] model(input sfce_op_e op, input sfce_size_e sz,
                                          input logic [31:0] x, input logic [31:0] y,
                                          input logic ci);
        int n;
        logic [32:0] s;
        logic [31:0] r;
        logic c;
        logic h;
        logic o;
        n = (sz == SFCE_SZ_BYTE) ? 8 : (sz == SFCE_SZ_WORD) ? 16 : 32;
        s = {1'b0, x & msk(sz)};
        c = 1'b0;
        h = 1'b0;
        o = 1'b0;
        if (op == SFCE_OP_ADD)
        begin
            s = {1'b0, x & msk(sz)} + {1'b0, y & msk(sz)} + ci;
            h = (5'(x[3:0]) + 5'(y[3:0]) + ci) > 5'h0f;
            o = (x[n-1] == y[n-1]) && (s[n-1] != x[n-1]);
        end
        else if (op == SFCE_OP_SUB)
        begin
            s = {1'b0, x & msk(sz)} - {1'b0, y & msk(sz)} - ci;
            h = 5'(x[3:0]) < (5'(y[3:0]) + ci);
            o = (x[n-1] != y[n-1]) && (s[n-1] != x[n-1]);
        end
        if (op != SFCE_OP_LOGIC)
            c = s[n];
        r = s[31:0] & msk(sz);
        return {r, o, r[n-1], r == 32'h0, h, ~^r[7:0], c};
    endfunction

    function automatic logic exp_cond(input logic [5:0] f, input logic [3:0] k);
        logic t;
        case (k[3:1])
            3'h0: t = f[5];
            3'h1: t = f[0];
            3'h2: t = f[3];
            3'h3: t = f[0] | f[3];
            3'h4: t = f[4];
            3'h5: t = f[1];
            3'h6: t = f[4] ^ f[5];
            default: t = (f[4] ^ f[5]) | f[3];
        endcase
        return t ^ k[0];
    endfunction

    task automatic ld_ctrl(input logic [4:0] v);
        @(posedge sys_clk);
        ctrl_load <= 1'b1;
        ctrl_load_val <= v;
        @(posedge sys_clk);
        ctrl_load <= 1'b0;
        #1;
        chk("ctrl_flags", v, ctrl_flags);
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        n_errors = 0;
        check_count = 0;
        seed = 1;
        cur = 6'h00;
        {rst_n, alu_valid, alu_use_carry, arith_load, ctrl_load, insn_retire} = 6'h00;
        {intr_req, debug_exc_req, task_nest_enter, task_return, str_step} = 5'h00;
        {alu_a, alu_b, src_index_in, dst_index_in} = 128'h0;
        alu_op = SFCE_OP_ADD;
        alu_size = SFCE_SZ_DWORD;
        arith_load_val = 6'h00;
        ctrl_load_val = 5'h00;
        cc = 4'h0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("reset arith", 32'h0, arith_flags);
        chk("reset ctrl", 32'h0, ctrl_flags);
        repeat (14) @(posedge sys_clk);
        rst_n <= 1'b1;
        // random operations with corner operands among them
        for (int i = 0; i < 300; i++)
        begin
            a = $random(seed);
            b = $random(seed);
            rv = $random(seed);
            if (i == 0) {a, b} = {32'h7fff_ffff, 32'h0000_0001};
            if (i == 1) {a, b} = {32'h0000_8000, 32'h0000_0001};
            if (i == 2) {a, b} = {32'h0000_00ff, 32'h0000_0001};
            if (i == 3) b = a;
            m = model(sfce_op_e'(rv % 3), sfce_size_e'((rv >> 4) % 3), a, b,
                      rv[8] & cur[0]);
            @(posedge sys_clk);
            alu_valid <= 1'b1;
            alu_a <= a;
            alu_b <= b;
            alu_op <= sfce_op_e'(rv % 3);
            alu_size <= sfce_size_e'((rv >> 4) % 3);
            alu_use_carry <= rv[8];
            cc <= rv[15:12];
            @(posedge sys_clk);
            alu_valid <= 1'b0;
            #1;
            cur = m[5:0];
            chk("alu_result", m[37:6], alu_result & msk(alu_size));
            chk("overflow_flag", m[5], arith_flags.overflow_flag);
            chk("sign_flag", m[4], arith_flags.sign_flag);
            chk("zero_flag", m[3], arith_flags.zero_flag);
            chk("adjust_flag", m[2], arith_flags.adjust_flag);
            chk("parity_flag", m[1], arith_flags.parity_flag);
            chk("carry_flag", m[0], arith_flags.carry_flag);
            chk("cond_true", exp_cond(cur, cc), cond_true);
        end
        // every subcode against every flag pattern
        for (int f = 0; f < 64; f++)
        begin
            @(posedge sys_clk);
            arith_load <= 1'b1;
            arith_load_val <= 6'(f);
            @(posedge sys_clk);
            arith_load <= 1'b0;
            for (int k = 0; k < 16; k++)
            begin
                @(posedge sys_clk);
                cc <= 4'(k);
                #1;
                rv = {31'h0, exp_cond(6'(f), 4'(k))};
                chk("cond_true", rv, cond_true);
            end
        end
        // interrupt enable gating
        @(posedge sys_clk);
        intr_req <= 1'b1;
        debug_exc_req <= 1'b1;
        ld_ctrl(5'b00000);
        chk("intr_accept", 1'b0, intr_accept);
        ld_ctrl(5'b01000);
        chk("intr_accept", 1'b1, intr_accept);
        // single step trap and resume suppression
        ld_ctrl(5'b10000);
        @(posedge sys_clk);
        insn_retire <= 1'b1;
        @(posedge sys_clk);
        insn_retire <= 1'b0;
        #1;
        chk("debug_trap", 1'b1, debug_trap);
        @(posedge sys_clk);
        #1;
        chk("debug_trap", 1'b0, debug_trap);
        ld_ctrl(5'b10001);
        chk("debug_exc_take", 1'b0, debug_exc_take);
        @(posedge sys_clk);
        insn_retire <= 1'b1;
        @(posedge sys_clk);
        insn_retire <= 1'b0;
        #1;
        chk("debug_trap", 1'b0, debug_trap);
        chk("ctrl_flags", 5'b10000, ctrl_flags);
        chk("debug_exc_take", 1'b1, debug_exc_take);
        // task nesting then nested return
        @(posedge sys_clk);
        task_nest_enter <= 1'b1;
        @(posedge sys_clk);
        task_nest_enter <= 1'b0;
        task_return <= 1'b1;
        #1;
        chk("nested_task_flag", 1'b1, ctrl_flags.nested_task_flag);
        chk("task_return_nested", 1'b1, task_return_nested);
        @(posedge sys_clk);
        task_return <= 1'b0;
        #1;
        chk("nested_task_flag", 1'b0, ctrl_flags.nested_task_flag);
        // index stepping in both directions
        for (int d = 0; d < 2; d++)
        begin
            ld_ctrl(d == 1 ? 5'b00100 : 5'b00000);
            a = (d == 1) ? 32'h0 : 32'hffff_ffff;
            b = $random(seed);
            @(posedge sys_clk);
            str_step <= 1'b1;
            src_index_in <= a;
            dst_index_in <= b;
            @(posedge sys_clk);
            str_step <= 1'b0;
            #1;
            chk("source_index", (d == 1) ? a - 1 : a + 1, source_index_register);
            chk("dest_index", (d == 1) ? b - 1 : b + 1, destination_index_register);
        end
        wrap_up();
    end
endmodule
